/* File: core/cffb_pkg.sv */
package cffb_pkg;
  localparam int CLK_KHZ = 40000;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h3_5;
  localparam logic [7:0] REGULATION_CONFIG_OFFSET = 8'h0_B;
  localparam logic [7:0] VOUT_PROTECT_CONFIG_OFFSET = 8'h0_C;
  localparam logic [7:0] INPUT_FAULT_FLAGS_OFFSET = 8'h0_D;
  localparam logic [7:0] INPUT_FAULT_MASKS_OFFSET = 8'h0_E;
  localparam logic [7:0] BATTERY_FAULT_FLAGS_OFFSET = 8'h0_F;
  localparam logic [7:0] BATTERY_FAULT_MASKS_OFFSET = 8'h1_0;
  localparam logic [7:0] REGULATION_CONFIG_RESET = 8'h0_0;
  localparam logic [7:0] VOUT_PROTECT_CONFIG_RESET = 8'h5_B;
  localparam logic [7:0] FLAGS_RESET = 8'h0_0;
  localparam logic [7:0] MASKS_RESET = 8'h0_0;
  localparam logic [7:0] REGULATION_WRITABLE = 8'h7_F;
  localparam int REG_TIMEOUT_DISABLE_BIT = 6;
  localparam int BATT_CURRENT_REG_ENABLE_BIT = 5;
  localparam int BATT_CURRENT_MARGIN_LSB = 3;
  localparam int BATT_VOLT_REG_ENABLE_BIT = 2;
  localparam int BATT_VOLT_MARGIN_LSB = 0;
  localparam int UNDERVOLT_LIMIT_LSB = 6;
  localparam int OVERVOLT_LIMIT_LSB = 4;
  localparam int OUTPUT_OVERVOLT_ENABLE_BIT = 3;
  localparam int OUTPUT_OVERVOLT_THRESHOLD_LSB = 1;
  localparam int OUTPUT_OVERVOLT_DEGLITCH_BIT = 0;
  localparam int RATIO_LOW_FLAG_BIT = 2;
  localparam int RATIO_HIGH_FLAG_BIT = 1;
  localparam int PEAK_FLAG_BIT = 0;
  localparam int REG_TIMEOUT_MS = 650;
  localparam int OVERVOLT_DEGLITCH_SHORT_US = 100;
  localparam int OVERVOLT_DEGLITCH_LONG_MS = 1;
  localparam int REG_TIMEOUT_CYCLES = REG_TIMEOUT_MS * CLK_KHZ;
  localparam int DEGLITCH_SHORT_CYCLES = OVERVOLT_DEGLITCH_SHORT_US * CLK_KHZ / 1000;
  localparam int DEGLITCH_LONG_CYCLES = OVERVOLT_DEGLITCH_LONG_MS * CLK_KHZ;
  localparam int CURRENT_REF_BASE_MA = 3000;
  localparam int CURRENT_REF_STEP_MA = 100;
  localparam int CURRENT_MARGIN_BASE_MA = 200;
  localparam int CURRENT_MARGIN_STEP_MA = 100;
  localparam int VOLT_REF_BASE_MV = 4000;
  localparam int VOLT_REF_STEP_MV = 25;
  localparam int VOLT_REF_MAX_MV = 5000;
  localparam int VOLT_MARGIN_STEP_MV = 50;
  localparam int UNDERVOLT_STEP_MV = 50;
  localparam int OVERVOLT_BASE_MV = 300;
  localparam int OVERVOLT_STEP_MV = 100;
  localparam int OUTPUT_OVERVOLT_BASE_MV = 4600;
  localparam int OUTPUT_OVERVOLT_STEP_MV = 200;
  localparam int RATIO_LOW_BASE = 1010;
  localparam int RATIO_LOW_STEP = 10;
  localparam int RATIO_HIGH_BASE = 1100;
  localparam int RATIO_HIGH_STEP = 50;
  localparam logic [3:0] ACK_SLOT = 4'h0_9;
  localparam logic [3:0] LAST_DATA_BIT = 4'h0_8;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_ADDR = 5'b0_0010,
    ST_PTR = 5'b0_0100,
    ST_WDATA = 5'b0_1000,
    ST_RDATA = 5'b1_0000
  } cffb_state_type;
endpackage

/* File: core/cffb_fault_bank.sv */
`timescale 1ns/1ps
module cffb_fault_bank
  import cffb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
  parameter int SWITCH_COUNT = 2,
  parameter int REG_TIMEOUT_LIMIT = REG_TIMEOUT_CYCLES,
  parameter int DEGLITCH_LONG_LIMIT = DEGLITCH_LONG_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic interruptN,
  input wire logic [7:0] inputFaultCond,
  input wire logic [7:0] batteryFaultCond,
  input wire logic [SWITCH_COUNT-1:0] chargeSwitchPeak,
  input wire logic [SWITCH_COUNT-1:0] dischargeSwitchPeak,
  input wire logic [15:0] inputRatio,
  input wire logic [1:0] inputRatioLowRef,
  input wire logic [1:0] inputRatioHighRef,
  input wire logic dividerMode,
  input wire logic battCurrentRegulating,
  input wire logic battVoltRegulating,
  input wire logic outputOvervoltRaw,
  input wire logic [5:0] battOvercurrentThreshold,
  input wire logic [5:0] battOvervoltThreshold,
  output logic chargeStop,
  output logic battOvercurrentLongDeglitch,
  output logic battOvervoltLongDeglitch,
  output logic [13:0] battCurrentRegPointMa,
  output logic [12:0] battVoltRegPointMv,
  output logic [7:0] midToOutUndervoltLimitMv,
  output logic [9:0] midToOutOvervoltLimitMv,
  output logic [12:0] outputOvervoltThresholdMv,
  output logic outputOvervoltTrip
);
  if (SWITCH_COUNT < 1 || REG_TIMEOUT_LIMIT < 1 || REG_TIMEOUT_LIMIT >= 2 ** 25 ||
      DEGLITCH_LONG_LIMIT <= DEGLITCH_SHORT_CYCLES || DEGLITCH_LONG_LIMIT >= 2 ** 20) begin : gBadParams
    $error("cffb_fault_bank: unsupported parameter value");
  end

  cffb_state_type stateReg;
  logic sclReg;
  logic sdaReg;
  logic [3:0] bitCntReg;
  logic [7:0] shiftReg;
  logic [7:0] txReg;
  logic [7:0] ptrReg;
  logic rwReg;
  logic nackReg;
  logic [7:0] regulationReg;
  logic [7:0] voutProtectReg;
  logic [7:0] inputFlagsReg;
  logic [7:0] inputMasksReg;
  logic [7:0] batteryFlagsReg;
  logic [7:0] batteryMasksReg;
  logic [24:0] timeoutCntReg;
  logic [19:0] deglitchCntReg;

  logic startSeen;
  logic stopSeen;
  logic sclRise;
  logic sclFall;
  logic loadByte;
  logic writeByte;
  logic [7:0] readData;
  logic [7:0] batteryCond;
  logic [16:0] lowLimit;
  logic [16:0] highLimit;

  // Bus inputs are synchronous, so plain one-cycle history gives the edges.
  assign startSeen = sclReg && sclIn && sdaReg && !sdaIn;
  assign stopSeen = sclReg && sclIn && !sdaReg && sdaIn;
  assign sclRise = sclIn && !sclReg;
  assign sclFall = !sclIn && sclReg;
  assign loadByte = sclFall && bitCntReg == ACK_SLOT &&
                    ((stateReg == ST_ADDR && rwReg) || (stateReg == ST_RDATA && !nackReg));
  assign writeByte = sclFall && bitCntReg == LAST_DATA_BIT && stateReg == ST_WDATA;

  always_comb begin
    unique case (ptrReg)
      REGULATION_CONFIG_OFFSET: readData = regulationReg;
      VOUT_PROTECT_CONFIG_OFFSET: readData = voutProtectReg;
      INPUT_FAULT_FLAGS_OFFSET: readData = inputFlagsReg;
      INPUT_FAULT_MASKS_OFFSET: readData = inputMasksReg;
      BATTERY_FAULT_FLAGS_OFFSET: readData = batteryFlagsReg;
      BATTERY_FAULT_MASKS_OFFSET: readData = batteryMasksReg;
      default: readData = 8'h0_0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sclReg <= 1'b1;
      sdaReg <= 1'b1;
    end else begin
      sclReg <= sclIn;
      sdaReg <= sdaIn;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stateReg <= ST_IDLE;
      bitCntReg <= 4'h0;
      shiftReg <= 8'h0_0;
      txReg <= 8'h0_0;
      ptrReg <= 8'h0_0;
      rwReg <= 1'b0;
      nackReg <= 1'b0;
      sdaOe <= 1'b0;
    end else if (startSeen) begin
      stateReg <= ST_ADDR;
      bitCntReg <= 4'h0;
      sdaOe <= 1'b0;
    end else if (stopSeen) begin
      stateReg <= ST_IDLE;
      sdaOe <= 1'b0;
    end else if (stateReg != ST_IDLE) begin
      if (sclRise) begin
        bitCntReg <= bitCntReg + 4'h1;
        if (bitCntReg < LAST_DATA_BIT) begin
          shiftReg <= {shiftReg[6:0], sdaIn};
        end
        if (bitCntReg == LAST_DATA_BIT) begin
          nackReg <= sdaIn;
        end
      end else if (loadByte) begin
        txReg <= readData;
        ptrReg <= ptrReg + 8'h0_1;
        sdaOe <= !readData[7];
        bitCntReg <= 4'h0;
        stateReg <= ST_RDATA;
      end else if (sclFall) begin
        unique case (stateReg)
          ST_RDATA: begin
            if (bitCntReg < LAST_DATA_BIT) begin
              txReg <= {txReg[6:0], 1'b0};
              sdaOe <= !txReg[6];
            end else if (bitCntReg == LAST_DATA_BIT) begin
              sdaOe <= 1'b0;
            end else begin
              stateReg <= ST_IDLE;
            end
          end
          default: begin
            if (bitCntReg == LAST_DATA_BIT) begin
              if (stateReg == ST_ADDR && shiftReg[7:1] != DEV_ADDR) begin
                stateReg <= ST_IDLE;
              end else begin
                sdaOe <= 1'b1;
                if (stateReg == ST_ADDR) begin
                  rwReg <= shiftReg[0];
                end
                if (stateReg == ST_PTR) begin
                  ptrReg <= shiftReg;
                end
                if (stateReg == ST_WDATA) begin
                  ptrReg <= ptrReg + 8'h0_1;
                end
              end
            end else if (bitCntReg == ACK_SLOT) begin
              sdaOe <= 1'b0;
              bitCntReg <= 4'h0;
              stateReg <= (stateReg == ST_ADDR) ? ST_PTR : ST_WDATA;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sdaOut <= 1'b0;
      regulationReg <= REGULATION_CONFIG_RESET;
      voutProtectReg <= VOUT_PROTECT_CONFIG_RESET;
      inputMasksReg <= MASKS_RESET;
      batteryMasksReg <= MASKS_RESET;
    end else if (writeByte) begin
      unique case (ptrReg)
        REGULATION_CONFIG_OFFSET: regulationReg <= shiftReg & REGULATION_WRITABLE;
        VOUT_PROTECT_CONFIG_OFFSET: voutProtectReg <= shiftReg;
        INPUT_FAULT_MASKS_OFFSET: inputMasksReg <= shiftReg;
        BATTERY_FAULT_MASKS_OFFSET: batteryMasksReg <= shiftReg;
        default: sdaOut <= 1'b0;
      endcase
    end
  end

  // Condition inputs hold while their cause lasts, so a set that wins over the read clear
  // keeps condition, pull-down and regulation flags alive until the cause is gone, while
  // pulse events clear on the read.
  always_comb begin
    batteryCond = batteryFaultCond;
    batteryCond[RATIO_LOW_FLAG_BIT] = {1'b0, inputRatio} < lowLimit;
    batteryCond[RATIO_HIGH_FLAG_BIT] = {1'b0, inputRatio} > highLimit;
    batteryCond[PEAK_FLAG_BIT] = |{chargeSwitchPeak, dischargeSwitchPeak};
  end
  assign lowLimit = 17'(RATIO_LOW_BASE + RATIO_LOW_STEP * int'(inputRatioLowRef)) << dividerMode;
  assign highLimit = 17'(RATIO_HIGH_BASE + RATIO_HIGH_STEP * int'(inputRatioHighRef)) << dividerMode;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      inputFlagsReg <= FLAGS_RESET;
      batteryFlagsReg <= FLAGS_RESET;
    end else begin
      for (int i = 0; i < 8; i++) begin
        inputFlagsReg[i] <= inputFaultCond[i] || (inputFlagsReg[i] &&
          !(loadByte && ptrReg == INPUT_FAULT_FLAGS_OFFSET));
        batteryFlagsReg[i] <= batteryCond[i] || (batteryFlagsReg[i] &&
          !(loadByte && ptrReg == BATTERY_FAULT_FLAGS_OFFSET));
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      interruptN <= 1'b1;
    end else begin
      interruptN <= !(|(inputFlagsReg & ~inputMasksReg) || |(batteryFlagsReg & ~batteryMasksReg));
    end
  end

  // The stop latches; a fresh write of the regulation settings lets charging resume.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      timeoutCntReg <= '0;
      chargeStop <= 1'b0;
    end else begin
      // A write releases the stop, but an expiry in the same cycle still wins.
      if (writeByte && ptrReg == REGULATION_CONFIG_OFFSET) begin
        chargeStop <= 1'b0;
      end
      if ((battCurrentRegulating || battVoltRegulating) && !regulationReg[REG_TIMEOUT_DISABLE_BIT]) begin
        if (timeoutCntReg < 25'(REG_TIMEOUT_LIMIT)) begin
          timeoutCntReg <= timeoutCntReg + 25'h1;
        end else begin
          chargeStop <= 1'b1;
        end
      end else begin
        timeoutCntReg <= '0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      deglitchCntReg <= '0;
      outputOvervoltTrip <= 1'b0;
    end else if (outputOvervoltRaw && voutProtectReg[OUTPUT_OVERVOLT_ENABLE_BIT]) begin
      if (deglitchCntReg < (voutProtectReg[OUTPUT_OVERVOLT_DEGLITCH_BIT] ?
          20'(DEGLITCH_LONG_LIMIT) : 20'(DEGLITCH_SHORT_CYCLES))) begin
        deglitchCntReg <= deglitchCntReg + 20'h1;
      end else begin
        outputOvervoltTrip <= 1'b1;
      end
    end else begin
      deglitchCntReg <= '0;
      outputOvervoltTrip <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      battOvercurrentLongDeglitch <= 1'b0;
      battOvervoltLongDeglitch <= 1'b0;
      battCurrentRegPointMa <= '0;
      battVoltRegPointMv <= '0;
      midToOutUndervoltLimitMv <= '0;
      midToOutOvervoltLimitMv <= '0;
      outputOvervoltThresholdMv <= '0;
    end else begin
      battOvercurrentLongDeglitch <= regulationReg[BATT_CURRENT_REG_ENABLE_BIT];
      battOvervoltLongDeglitch <= regulationReg[BATT_VOLT_REG_ENABLE_BIT];
      battCurrentRegPointMa <= 14'(CURRENT_REF_BASE_MA + CURRENT_REF_STEP_MA * int'(battOvercurrentThreshold)
        - CURRENT_MARGIN_BASE_MA - CURRENT_MARGIN_STEP_MA *
        int'(regulationReg[BATT_CURRENT_MARGIN_LSB +: 2]));
      battVoltRegPointMv <= 13'((VOLT_REF_BASE_MV + VOLT_REF_STEP_MV * int'(battOvervoltThreshold) > VOLT_REF_MAX_MV ?
        VOLT_REF_MAX_MV : VOLT_REF_BASE_MV + VOLT_REF_STEP_MV * int'(battOvervoltThreshold))
        - VOLT_MARGIN_STEP_MV * (int'(regulationReg[BATT_VOLT_MARGIN_LSB +: 2]) + 1));
      midToOutUndervoltLimitMv <= 8'(UNDERVOLT_STEP_MV * (int'(voutProtectReg[UNDERVOLT_LIMIT_LSB +: 2]) + 1));
      midToOutOvervoltLimitMv <= 10'(OVERVOLT_BASE_MV +
        OVERVOLT_STEP_MV * int'(voutProtectReg[OVERVOLT_LIMIT_LSB +: 2]));
      outputOvervoltThresholdMv <= 13'(OUTPUT_OVERVOLT_BASE_MV +
        OUTPUT_OVERVOLT_STEP_MV * int'(voutProtectReg[OUTPUT_OVERVOLT_THRESHOLD_LSB +: 2]));
    end
  end
endmodule

/* File: test/cffb_host.sv */
`timescale 1ns/1ps
module cffb_host
  import cffb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic sdaWire,
  output logic sclOut,
  output logic sdaLow
);
  initial begin
    sclOut <= 1'b1;
    sdaLow <= 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Data moves only while the serial clock is low, well clear of the rise that the device samples.
  task automatic bitx(input logic drv, output logic seen);
    sdaLow <= drv;
    wt(3);
    sclOut <= 1'b1;
    wt(2);
    seen = sdaWire;
    wt(2);
    sclOut <= 1'b0;
    wt(1);
  endtask
  task automatic start();
    sdaLow <= 1'b0;
    wt(2);
    sclOut <= 1'b1;
    wt(3);
    sdaLow <= 1'b1;
    wt(3);
    sclOut <= 1'b0;
    wt(2);
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    wt(2);
    sclOut <= 1'b1;
    wt(3);
    sdaLow <= 1'b0;
    wt(3);
  endtask
  // The ninth slot is always released: the device acks a write, and a read ends on a nack.
  task automatic byteX(input logic [7:0] tx, input logic rd, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(rd ? 1'b0 : ~tx[i], s);
      rx[i] = s;
    end
    bitx(1'b0, s);
    ack = ~s;
  endtask
  task automatic wrReg(input logic [7:0] p, input logic [7:0] v, output logic ok);
    logic [7:0] x;
    logic k1, k2, k3;
    start();
    byteX({DEV_ADDR, 1'b0}, 1'b0, x, k1);
    byteX(p, 1'b0, x, k2);
    byteX(v, 1'b0, x, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic rdReg(input logic [7:0] p, output logic [7:0] v);
    logic [7:0] x;
    logic k;
    start();
    byteX({DEV_ADDR, 1'b0}, 1'b0, x, k);
    byteX(p, 1'b0, x, k);
    stop();
    start();
    byteX({DEV_ADDR, 1'b1}, 1'b0, x, k);
    byteX(8'h00, 1'b1, v, k);
    stop();
  endtask
endmodule

/* File: test/cffb_checker.sv */
`timescale 1ns/1ps
module cffb_checker
  import cffb_pkg::*;
#(
  parameter int REG_TIMEOUT_LIMIT = 50
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic outputOvervoltRaw,
  input wire logic outputOvervoltTrip,
  input wire logic battCurrentRegulating,
  input wire logic battVoltRegulating,
  input wire logic chargeStop,
  input wire logic [5:0] battOvercurrentThreshold,
  input wire logic [5:0] battOvervoltThreshold,
  input wire logic [13:0] battCurrentRegPointMa,
  input wire logic [12:0] battVoltRegPointMv,
  input wire logic [7:0] midToOutUndervoltLimitMv,
  input wire logic [9:0] midToOutOvervoltLimitMv,
  input wire logic [12:0] outputOvervoltThresholdMv
);
  logic [1:0] live;
  int rawCnt, regCnt, iRef, vRef;
  // The references lag one cycle, matching the registered regulation points.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      live <= 2'b00;
      rawCnt <= 0;
      regCnt <= 0;
      iRef <= 0;
      vRef <= 0;
    end else begin
      live <= {live[0], 1'b1};
      rawCnt <= outputOvervoltRaw ? rawCnt + 1 : 0;
      regCnt <= (battCurrentRegulating | battVoltRegulating) ? regCnt + 1 : 0;
      iRef <= CURRENT_REF_BASE_MA + CURRENT_REF_STEP_MA * battOvercurrentThreshold;
      vRef <= (VOLT_REF_BASE_MV + VOLT_REF_STEP_MV * battOvervoltThreshold > VOLT_REF_MAX_MV) ? VOLT_REF_MAX_MV :
        VOLT_REF_BASE_MV + VOLT_REF_STEP_MV * battOvervoltThreshold;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_tripRise; $rose(outputOvervoltTrip); endsequence
  sequence s_stopRise; $rose(chargeStop); endsequence
  property p_iPt; live[1] |-> (iRef - battCurrentRegPointMa) inside {200, 300, 400, 500}; endproperty
  a_iPt: assert property (p_iPt) else $error("current regulation point off");
  property p_vPt; live[1] |-> (vRef - battVoltRegPointMv) inside {50, 100, 150, 200}; endproperty
  a_vPt: assert property (p_vPt) else $error("voltage regulation point off");
  property p_midLim; live[1] |-> midToOutUndervoltLimitMv inside {50, 100, 150, 200}; endproperty
  a_midLim: assert property (p_midLim) else $error("undervolt limit off");
  property p_midOv; live[1] |-> midToOutOvervoltLimitMv inside {300, 400, 500, 600}; endproperty
  a_midOv: assert property (p_midOv) else $error("overvolt limit off");
  property p_outThr; live[1] |-> outputOvervoltThresholdMv inside {4600, 4800, 5000, 5200}; endproperty
  a_outThr: assert property (p_outThr) else $error("output threshold off");
  property p_tripHold; s_tripRise |-> rawCnt >= DEGLITCH_SHORT_CYCLES; endproperty
  a_tripHold: assert property (p_tripHold) else $error("trip before deglitch");
  property p_tripDrop; !outputOvervoltRaw |=> !outputOvervoltTrip; endproperty
  a_tripDrop: assert property (p_tripDrop) else $error("trip without cause");
  property p_stopHold; s_stopRise |-> regCnt >= REG_TIMEOUT_LIMIT; endproperty
  a_stopHold: assert property (p_stopHold) else $error("charge stop too early");
endmodule
bind cffb_fault_bank cffb_checker #(.REG_TIMEOUT_LIMIT(REG_TIMEOUT_LIMIT)) chk (.sys_clk, .nrst, .outputOvervoltRaw,
  .outputOvervoltTrip, .battCurrentRegulating, .battVoltRegulating, .chargeStop, .battOvercurrentThreshold,
  .battOvervoltThreshold, .battCurrentRegPointMa, .battVoltRegPointMv, .midToOutUndervoltLimitMv,
  .midToOutOvervoltLimitMv, .outputOvervoltThresholdMv);

/* File: test/cffb_fault_bank_bench.sv */
`timescale 1ns/1ps
module cffb_fault_bank_bench
  import cffb_pkg::*;
;
  localparam int TO = 50;
  logic sys_clk = 1'b0;
  logic nrst, sdaOut, sdaOe, interruptN, dividerMode, battCurrentRegulating, battVoltRegulating;
  logic outputOvervoltRaw, chargeStop, ocDeg, ovDeg, trip, hostScl, hostLow, sdaWire, ok;
  logic [7:0] inputFaultCond, batteryFaultCond, d, v, mk, fr, bv, uvLim;
  logic [1:0] chargeSwitchPeak, dischargeSwitchPeak, inputRatioLowRef, inputRatioHighRef, cc;
  logic [15:0] inputRatio;
  logic [5:0] thrC, thrV;
  logic [13:0] iPt;
  logic [12:0] vPt, outThr;
  logic [9:0] ovLim;
  logic [31:0] r;
  logic [7:0] offs [7] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h20};
  int seed, errCount, testsRun;
  cffb_fault_bank #(.REG_TIMEOUT_LIMIT(TO), .DEGLITCH_LONG_LIMIT(4100)) DUT (.sys_clk, .nrst, .sclIn(hostScl),
    .sdaIn(sdaWire), .sdaOut, .sdaOe, .interruptN, .inputFaultCond, .batteryFaultCond, .chargeSwitchPeak,
    .dischargeSwitchPeak, .inputRatio, .inputRatioLowRef, .inputRatioHighRef, .dividerMode,
    .battCurrentRegulating, .battVoltRegulating, .outputOvervoltRaw, .battOvercurrentThreshold(thrC),
    .battOvervoltThreshold(thrV), .chargeStop, .battOvercurrentLongDeglitch(ocDeg),
    .battOvervoltLongDeglitch(ovDeg), .battCurrentRegPointMa(iPt), .battVoltRegPointMv(vPt),
    .midToOutUndervoltLimitMv(uvLim), .midToOutOvervoltLimitMv(ovLim), .outputOvervoltThresholdMv(outThr),
    .outputOvervoltTrip(trip));
  // The data line has a pull-up, so it reads high unless somebody pulls it low.
  assign sdaWire = ~hostLow & ~(sdaOe & ~sdaOut);
  cffb_host host (.sys_clk, .sdaWire, .sclOut(hostScl), .sdaLow(hostLow));
  always #12.5 sys_clk = ~sys_clk;
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    testsRun++;
    if (s !== e) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  function automatic int voltPt(int t, int m);
    int x;
    x = VOLT_REF_BASE_MV + VOLT_REF_STEP_MV * t;
    if (x > VOLT_REF_MAX_MV) x = VOLT_REF_MAX_MV;
    return x - VOLT_MARGIN_STEP_MV * (m + 1);
  endfunction
  // Ratio causes sit one count past the limit; the idle ratio lies between both limits in either mode.
  task automatic setSrc(input int j, input logic on);
    int lim;
    lim = (r[0] ? 2 : 1) * (j == 10 ? RATIO_LOW_BASE + RATIO_LOW_STEP * r[2:1] : RATIO_HIGH_BASE + RATIO_HIGH_STEP * r[4:3]);
    if (j < 8) inputFaultCond[j] <= on;
    else if (j > 10) batteryFaultCond[j - 8] <= on;
    else if (j == 8) {chargeSwitchPeak, dischargeSwitchPeak} <= on ? 4'(1 << r[6:5]) : 4'h0;
    else inputRatio <= 16'(on ? (j == 10 ? lim - 1 : lim + 1) : (r[0] ? 2140 : 1070));
  endtask
  task automatic tripRun(input int n, input logic en);
    outputOvervoltRaw <= 1'b1;
    wt(n - 20);
    chk("tripEarly", trip, 1'b0);
    wt(40);
    chk("trip", trip, en);
    outputOvervoltRaw <= 1'b0;
    wt(2);
    chk("tripOff", trip, 1'b0);
  endtask
  initial begin
    wt(90000);
    errCount++;
    conclude();
  end
  initial begin
    seed = 71595;
    errCount = 0;
    testsRun = 0;
    nrst <= 1'b0;
    {inputFaultCond, batteryFaultCond, chargeSwitchPeak, dischargeSwitchPeak} <= '0;
    {dividerMode, battCurrentRegulating, battVoltRegulating, outputOvervoltRaw} <= '0;
    {inputRatioLowRef, inputRatioHighRef, thrC, thrV} <= '0;
    inputRatio <= 16'(1070);
    wt(5);
    nrst <= 1'b1;
    wt(3);
    host.wrReg(8'h0D, 8'hFF, ok);
    chk("ack", ok, 1'b1);
    for (int i = 0; i < 7; i++) begin
      host.rdReg(offs[i], d);
      chk("reset", d, i == 1 ? 8'h5B : 8'h00);
    end
    chk("sdaOut", sdaOut, 1'b0);
    host.start();
    host.byteX({~DEV_ADDR_DEFAULT, 1'b0}, 1'b0, d, ok);
    host.stop();
    chk("nack", ok, 1'b0);
    for (int m = 0; m < 4; m++) begin
      r = $random(seed);
      thrC <= r[13:8];
      thrV <= m == 3 ? 6'h3F : (m == 2 ? 6'h28 : r[21:16]);
      v = {2'b11, r[0], 2'(m), r[1], 2'(m)};
      host.wrReg(8'h0B, v, ok);
      host.rdReg(8'h0B, d);
      chk("regulation", d, v & 8'h7F);
      chk("ocDeg", ocDeg, v[5]);
      chk("ovDeg", ovDeg, v[2]);
      chk("iPt", iPt, 16'(3000 + 100 * thrC - 200 - 100 * m));
      chk("vPt", vPt, 16'(voltPt(thrV, m)));
    end
    for (int c = 0; c < 4; c++) begin
      cc = 2'(c);
      host.wrReg(8'h0C, {cc, cc, 1'b1, cc, 1'b0}, ok);
      wt(2);
      chk("uvLim", uvLim, 16'(50 * (c + 1)));
      chk("ovLim", ovLim, 16'(300 + 100 * c));
      chk("outThr", outThr, 16'(4600 + 200 * c));
    end
    tripRun(DEGLITCH_SHORT_CYCLES, 1'b1);
    host.wrReg(8'h0C, 8'h5B, ok);
    tripRun(4100, 1'b1);
    host.wrReg(8'h0C, 8'h53, ok);
    tripRun(4100, 1'b0);
    host.wrReg(8'h0B, 8'h00, ok);
    battCurrentRegulating <= 1'b1;
    wt(TO - 10);
    battCurrentRegulating <= 1'b0;
    wt(2);
    chk("stopShort", chargeStop, 1'b0);
    battVoltRegulating <= 1'b1;
    wt(TO + 10);
    chk("stop", chargeStop, 1'b1);
    battVoltRegulating <= 1'b0;
    host.wrReg(8'h0B, 8'h40, ok);
    battCurrentRegulating <= 1'b1;
    wt(TO + 10);
    chk("stopOff", chargeStop, 1'b0);
    battCurrentRegulating <= 1'b0;
    for (int j = 0; j < 16; j++) begin
      r = $random(seed);
      // Odd steps run in divider mode, so the two ratio flags meet different modes.
      r[0] = j[0];
      dividerMode <= r[0];
      inputRatioLowRef <= r[2:1];
      inputRatioHighRef <= r[4:3];
      inputRatio <= 16'(r[0] ? 2140 : 1070);
      fr = j < 8 ? 8'h0D : 8'h0F;
      bv = 8'(1 << (j % 8));
      mk = r[15:8];
      host.wrReg(fr + 8'h01, mk, ok);
      setSrc(j, 1'b1);
      wt(2);
      if (!((16'hBEE8 >> j) & 1)) setSrc(j, 1'b0);
      wt(2);
      chk("irq", interruptN, mk[j % 8]);
      host.rdReg(fr, d);
      chk("flagSet", d, bv);
      host.rdReg(fr, d);
      chk("flagHeld", d, 16'hBEE8 >> j & 1 ? bv : 8'h00);
      setSrc(j, 1'b0);
      wt(2);
      host.rdReg(fr, d);
      chk("flagLate", d, 16'hBEE8 >> j & 1 ? bv : 8'h00);
      host.rdReg(fr, d);
      chk("flagGone", d, 8'h00);
      chk("irqOff", interruptN, 1'b1);
    end
    conclude();
  end
endmodule
